// ### hw/status_pkg.sv
// Constants, register map and types shared by the status register sets
package status_pkg;

	localparam int MASK_W   = 15;
	localparam int DATA_W   = 32;
	localparam int ADDR_W   = 8;
	localparam int NUM_SETS = 3;
	localparam int IRQ_W    = 4;

	// Set indices
	localparam logic [1:0] SET_LIMIT = 2'h0;
	localparam logic [1:0] SET_POWER = 2'h1;
	localparam logic [1:0] SET_DATA  = 2'h2;
	localparam logic [1:0] SET_NONE  = 2'h3;

	// Set base byte addresses
	localparam logic [7:0] OFS_LIMIT_BASE = 8'h00;
	localparam logic [7:0] OFS_POWER_BASE = 8'h20;
	localparam logic [7:0] OFS_DATA_BASE  = 8'h40;
	localparam logic [7:0] SET_BASE_MASK  = 8'he0;

	// Register offsets inside a set
	localparam logic [4:0] OFS_COND   = 5'h00;
	localparam logic [4:0] OFS_EVENT  = 5'h04;
	localparam logic [4:0] OFS_ENABLE = 5'h08;
	localparam logic [4:0] OFS_PTR    = 5'h0c;
	localparam logic [4:0] OFS_NTR    = 5'h10;

	// Interrupt registers
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h60;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h64;

	// Interrupt status bit positions
	localparam int IRQ_LIMIT_BIT = 0;
	localparam int IRQ_POWER_BIT = 1;
	localparam int IRQ_DATA_BIT  = 2;
	localparam int IRQ_RANGE_BIT = 3;

	// Reset values
	localparam logic [MASK_W-1:0] MASK_RESET  = 15'h0000;
	localparam logic [IRQ_W-1:0]  IRQ_RESET   = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

	typedef enum {REG_COND, REG_EVENT, REG_ENABLE, REG_PTR, REG_NTR, REG_NONE} reg_sel_t;

endpackage

// ### hw/status_set.sv
// One status register set: condition edge detection, event latch and masks
`timescale 1ns/1ns
`default_nettype none

module status_set
	import status_pkg::*;
#(
	parameter int W = MASK_W
)
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] cond,
	input  wire logic         enable_wr,
	input  wire logic         ptr_wr,
	input  wire logic         ntr_wr,
	input  wire logic [W-1:0] wdata,
	input  wire logic         event_clr,
	output logic      [W-1:0] event_q,
	output logic      [W-1:0] enable_q,
	output logic      [W-1:0] ptr_q,
	output logic      [W-1:0] ntr_q,
	output logic      [W-1:0] hit,
	output logic              summary
);

	logic [W-1:0] prev_q;

	// Condition history for edge detection; never touched by a query
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prev_q <= W'(0);
		else
			prev_q <= cond;
	end

	assign hit = (cond & ~prev_q & ptr_q) | (~cond & prev_q & ntr_q);

	// A hit in the cycle of the clearing read survives into the register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			event_q <= W'(0);
		else
			event_q <= (event_clr ? W'(0) : event_q) | hit;
	end

	// Masks only change on writes; preset has no path into them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			enable_q <= W'(MASK_RESET);
		else if (enable_wr)
			enable_q <= wdata;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ptr_q <= W'(MASK_RESET);
		else if (ptr_wr)
			ptr_q <= wdata;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ntr_q <= W'(MASK_RESET);
		else if (ntr_wr)
			ntr_q <= wdata;
	end

	assign summary = |(event_q & enable_q);

endmodule // status_set

`default_nettype wire

// ### hw/status_register_sets.sv
// Top of the limit fail, questionable power and questionable data status sets
`timescale 1ns/1ns
`default_nettype none

module status_register_sets
	import status_pkg::*;
#(
	parameter int W = MASK_W
)
(
	input  wire logic              SYS_CLK,
	input  wire logic              RESET,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	input  wire logic [W-1:0]      LIMIT_COND,
	input  wire logic [W-1:0]      POWER_COND,
	input  wire logic [W-1:0]      DATA_COND,
	input  wire logic              PRESET,
	output logic                   LIMIT_SUMMARY,
	output logic                   POWER_SUMMARY,
	output logic                   DATA_SUMMARY,
	output logic                   IRQ
);

	// Which set an address falls into
	function automatic logic [1:0] set_of(input logic [ADDR_W-1:0] a);
		logic [1:0] s;
		s = SET_NONE;
		case (a & SET_BASE_MASK)
			OFS_LIMIT_BASE: s = SET_LIMIT;
			OFS_POWER_BASE: s = SET_POWER;
			OFS_DATA_BASE:  s = SET_DATA;
			default:        s = SET_NONE;
		endcase
		return s;
	endfunction

	// Which register of a set an address selects
	function automatic reg_sel_t reg_of(input logic [ADDR_W-1:0] a);
		reg_sel_t r;
		r = REG_NONE;
		case (a[4:0])
			OFS_COND:   r = REG_COND;
			OFS_EVENT:  r = REG_EVENT;
			OFS_ENABLE: r = REG_ENABLE;
			OFS_PTR:    r = REG_PTR;
			OFS_NTR:    r = REG_NTR;
			default:    r = REG_NONE;
		endcase
		return r;
	endfunction

	function automatic logic is_mask(input reg_sel_t r);
		return (r == REG_ENABLE) || (r == REG_PTR) || (r == REG_NTR);
	endfunction

	logic     [W-1:0]        cond_raw  [NUM_SETS];
	logic     [W-1:0]        sync1_q   [NUM_SETS];
	logic     [W-1:0]        cond_s    [NUM_SETS];
	logic     [W-1:0]        event_s   [NUM_SETS];
	logic     [W-1:0]        enable_s  [NUM_SETS];
	logic     [W-1:0]        ptr_s     [NUM_SETS];
	logic     [W-1:0]        ntr_s     [NUM_SETS];
	logic     [W-1:0]        hit_s     [NUM_SETS];
	logic     [NUM_SETS-1:0] sum_vec;
	logic     [NUM_SETS-1:0] sum_prev_q;
	logic     [NUM_SETS-1:0] enable_wr;
	logic     [NUM_SETS-1:0] ptr_wr;
	logic     [NUM_SETS-1:0] ntr_wr;
	logic     [NUM_SETS-1:0] event_clr;
	logic     [1:0]          acc_set;
	reg_sel_t                acc_reg;
	logic                    set_sel;
	logic                    val_ok;
	logic                    range_err;
	logic     [DATA_W-1:0]   rd_val;
	logic     [DATA_W-1:0]   rdata_q;
	logic     [IRQ_W-1:0]    irq_status_q;
	logic     [IRQ_W-1:0]    irq_mask_q;
	logic     [IRQ_W-1:0]    irq_set;
	logic     [IRQ_W-1:0]    irq_clr;

	assign cond_raw[SET_LIMIT] = LIMIT_COND;
	assign cond_raw[SET_POWER] = POWER_COND;
	assign cond_raw[SET_DATA]  = DATA_COND;

	// Condition pins come from outside the clock domain
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			for (int i = 0; i < NUM_SETS; i++)
			begin
				sync1_q[i] <= W'(0);
				cond_s[i]  <= W'(0);
			end
		end
		else
		begin
			for (int i = 0; i < NUM_SETS; i++)
			begin
				sync1_q[i] <= cond_raw[i];
				cond_s[i]  <= sync1_q[i];
			end
		end
	end

	assign acc_set   = set_of(ADDR);
	assign acc_reg   = reg_of(ADDR);
	assign set_sel   = (acc_set != SET_NONE) && (acc_reg != REG_NONE);
	// Integers above the 15-bit range are refused whole rather than truncated
	assign val_ok    = (WDATA[DATA_W-1:W] == '0);
	assign range_err = WR && set_sel && is_mask(acc_reg) && !val_ok;

	genvar g;
	generate
		for (g = 0; g < NUM_SETS; g++)
		begin : g_set
			assign enable_wr[g] = WR && val_ok && (acc_set == 2'(g)) && (acc_reg == REG_ENABLE);
			assign ptr_wr[g]    = WR && val_ok && (acc_set == 2'(g)) && (acc_reg == REG_PTR);
			assign ntr_wr[g]    = WR && val_ok && (acc_set == 2'(g)) && (acc_reg == REG_NTR);
			assign event_clr[g] = RD && (acc_set == 2'(g)) && (acc_reg == REG_EVENT);

			status_set #(
				.W (W)
			) u_set (
				.clk       (SYS_CLK),
				.rst       (RESET),
				.cond      (cond_s[g]),
				.enable_wr (enable_wr[g]),
				.ptr_wr    (ptr_wr[g]),
				.ntr_wr    (ntr_wr[g]),
				.wdata     (WDATA[W-1:0]),
				.event_clr (event_clr[g]),
				.event_q   (event_s[g]),
				.enable_q  (enable_s[g]),
				.ptr_q     (ptr_s[g]),
				.ntr_q     (ntr_s[g]),
				.hit       (hit_s[g]),
				.summary   (sum_vec[g])
			);
		end
	endgenerate

	// Read mux; every value is the plain binary of the bits, i.e. the weighted sum
	always_comb
	begin
		rd_val = RDATA_RESET;
		if (ADDR == OFS_IRQ_STATUS)
			rd_val[IRQ_W-1:0] = irq_status_q;
		else if (ADDR == OFS_IRQ_MASK)
			rd_val[IRQ_W-1:0] = irq_mask_q;
		else if (set_sel)
		begin
			case (acc_reg)
				REG_COND:   rd_val[W-1:0] = cond_s[acc_set];
				REG_EVENT:  rd_val[W-1:0] = event_s[acc_set];
				REG_ENABLE: rd_val[W-1:0] = enable_s[acc_set];
				REG_PTR:    rd_val[W-1:0] = ptr_s[acc_set];
				REG_NTR:    rd_val[W-1:0] = ntr_s[acc_set];
				default:    rd_val = RDATA_RESET;
			endcase
		end
	end

	// Data is valid only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
			rdata_q <= RDATA_RESET;
		else if (RD)
			rdata_q <= rd_val;
		else
			rdata_q <= RDATA_RESET;
	end

	assign RDATA = rdata_q;

	// Interrupt events: a set summary going high, or a refused mask value
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
			sum_prev_q <= '0;
		else
			sum_prev_q <= sum_vec;
	end

	assign irq_set = {range_err, sum_vec & ~sum_prev_q};
	assign irq_clr = (WR && (ADDR == OFS_IRQ_STATUS)) ? WDATA[IRQ_W-1:0] : IRQ_RESET;

	// Set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
			irq_status_q <= IRQ_RESET;
		else if (PRESET)
			irq_status_q <= irq_set;
		else
			irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
	end

	// Preset returns the interrupt mask to its default and clears the interrupt status except new sets; set masks are kept
	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
			irq_mask_q <= IRQ_RESET;
		else if (PRESET)
			irq_mask_q <= IRQ_RESET;
		else if (WR && (ADDR == OFS_IRQ_MASK))
			irq_mask_q <= WDATA[IRQ_W-1:0];
	end

	assign IRQ           = |(irq_status_q & irq_mask_q);
	assign LIMIT_SUMMARY = sum_vec[SET_LIMIT];
	assign POWER_SUMMARY = sum_vec[SET_POWER];
	assign DATA_SUMMARY  = sum_vec[SET_DATA];

	// Checks
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET);

	localparam logic [7:0] A_LIM_COND  = OFS_LIMIT_BASE + 8'(OFS_COND);
	localparam logic [7:0] A_LIM_EVENT = OFS_LIMIT_BASE + 8'(OFS_EVENT);
	localparam logic [7:0] A_LIM_EN    = OFS_LIMIT_BASE + 8'(OFS_ENABLE);
	localparam logic [7:0] A_POW_PTR   = OFS_POWER_BASE + 8'(OFS_PTR);
	localparam logic [7:0] A_DAT_NTR   = OFS_DATA_BASE + 8'(OFS_NTR);

	sequence s_rd_lim_cond;
		RD && (ADDR == A_LIM_COND);
	endsequence

	a_cond_read_value:
	assert property (s_rd_lim_cond |=> RDATA == {{(DATA_W-W){1'b0}}, $past(cond_s[SET_LIMIT])})
		else $error("condition read value wrong");

	a_cond_read_stable:
	assert property (s_rd_lim_cond ##1 (s_rd_lim_cond and $stable(cond_s[SET_LIMIT]))
		|=> RDATA == $past(RDATA))
		else $error("condition read altered state");

	a_event_read_clear:
	assert property (RD && (ADDR == A_LIM_EVENT) |=> event_s[SET_LIMIT] == $past(hit_s[SET_LIMIT]))
		else $error("event register not cleared by read");

	a_mask_write_load:
	assert property (WR && (ADDR == A_LIM_EN) && (WDATA[DATA_W-1:W] == '0)
		|=> enable_s[SET_LIMIT] == $past(WDATA[W-1:0]))
		else $error("enable mask not loaded");

	a_range_refused:
	assert property (WR && (ADDR == A_POW_PTR) && (WDATA[DATA_W-1:W] != '0)
		|=> $stable(ptr_s[SET_POWER]) && irq_status_q[IRQ_RANGE_BIT])
		else $error("out of range mask value accepted");

	a_preset_keeps_masks:
	assert property (PRESET && !WR
		|=> $stable(enable_s[SET_DATA]) && $stable(ptr_s[SET_DATA]) && $stable(ntr_s[SET_DATA]))
		else $error("preset changed a mask");

	a_rise_latches_event:
	assert property (ptr_s[SET_DATA][0] && $rose(cond_s[SET_DATA][0]) |=> event_s[SET_DATA][0])
		else $error("rising edge not latched");

	a_fall_latches_event:
	assert property (ntr_s[SET_POWER][1] && $fell(cond_s[SET_POWER][1]) |=> event_s[SET_POWER][1])
		else $error("falling edge not latched");

	a_mask_read_value:
	assert property (RD && (ADDR == A_DAT_NTR) |=> RDATA == {{(DATA_W-W){1'b0}}, $past(ntr_s[SET_DATA])})
		else $error("mask read value wrong");

	a_sets_independent:
	assert property (WR && (ADDR == A_LIM_EN) |=> $stable(enable_s[SET_POWER]) && $stable(enable_s[SET_DATA]))
		else $error("write leaked into another set");

	a_summary_to_irq:
	assert property ($rose(LIMIT_SUMMARY) |=> irq_status_q[IRQ_LIMIT_BIT])
		else $error("summary rise not flagged");

	a_read_one_cycle:
	assert property (RD ##1 !RD |=> RDATA == RDATA_RESET)
		else $error("read data held too long");

	a_event_read_data:
	assert property (RD && (ADDR == A_LIM_EVENT) |=> RDATA == {{(DATA_W-W){1'b0}}, $past(event_s[SET_LIMIT])})
		else $error("event read value wrong");

	// Only a read of the set's own event register may drop a latched bit
	a_event_sticky:
	assert property (!event_clr[SET_POWER]
		|=> (event_s[SET_POWER] & $past(event_s[SET_POWER])) == $past(event_s[SET_POWER]))
		else $error("event bit lost without a read");

	a_event_clear_local:
	assert property (RD && (ADDR == A_LIM_EVENT)
		|=> (event_s[SET_DATA] & $past(event_s[SET_DATA])) == $past(event_s[SET_DATA]))
		else $error("event read cleared another set");

	a_ptr_write_load:
	assert property (WR && (ADDR == A_POW_PTR) && (WDATA[DATA_W-1:W] == '0)
		|=> ptr_s[SET_POWER] == $past(WDATA[W-1:0]))
		else $error("positive transition mask not loaded");

	a_ntr_write_load:
	assert property (WR && (ADDR == A_DAT_NTR) && (WDATA[DATA_W-1:W] == '0)
		|=> ntr_s[SET_DATA] == $past(WDATA[W-1:0]))
		else $error("negative transition mask not loaded");

	a_range_flag_clear:
	assert property (WR && (ADDR == OFS_IRQ_STATUS) && WDATA[IRQ_RANGE_BIT] |=> !irq_status_q[IRQ_RANGE_BIT])
		else $error("range flag not cleared by write");

	// A summary rise in the clearing cycle keeps its flag, so only quiet cycles are checked
	a_limit_flag_clear:
	assert property (WR && (ADDR == OFS_IRQ_STATUS) && WDATA[IRQ_LIMIT_BIT] && !irq_set[IRQ_LIMIT_BIT]
		|=> !irq_status_q[IRQ_LIMIT_BIT])
		else $error("summary flag not cleared by write");

	a_unmapped_read_zero:
	assert property (RD && !set_sel && (ADDR != OFS_IRQ_STATUS) && (ADDR != OFS_IRQ_MASK)
		|=> RDATA == RDATA_RESET)
		else $error("unmapped read returned data");

	c_event_read: cover property (RD && (ADDR == A_LIM_EVENT) && (event_s[SET_LIMIT] != '0));
	c_irq_raised: cover property ($rose(IRQ));
	c_range_error: cover property (range_err);
	c_preset_seen: cover property (PRESET && (enable_s[SET_DATA] != '0));
	c_read_pair: cover property (s_rd_lim_cond ##1 s_rd_lim_cond);

endmodule // status_register_sets

`default_nettype wire

// ### tb/ctrl_model.sv
// Remote controller model: issues one status command at a time on the register port
`timescale 1ns/1ns
`default_nettype none

module ctrl_model
	import status_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [DATA_W-1:0] rdata,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] wdata,
	output logic                   wr,
	output logic                   rd
);
	initial
	begin
		addr  = '0;
		wdata = '0;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// Callers keep mask values in 0 to 32767 unless a refusal is meant
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// A command has fully returned before the caller can start the next one
	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	// Two reads back to back: the strobe stays high across both edges
	task automatic read_pair(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d1, d2);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		rd <= 1'b0;
		d1 = rdata;
		@(posedge clk);
		d2 = rdata;
	endtask
endmodule // ctrl_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the three status register sets
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import status_pkg::*;

	logic              sys_clk;
	logic              reset;
	logic              preset;
	logic [MASK_W-1:0] cond [3];
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              wr;
	logic              rd;
	logic [2:0]        summ;
	logic              irq;
	int                err_count;
	int                comparisons;
	logic [31:0]       seed;
	logic [31:0]       d;
	logic [31:0]       d2;
	logic [MASK_W-1:0] m [3][3];
	logic [MASK_W-1:0] pt, nt, en, od, nw, ex;
	logic [4:0]        mofs [3];
	int                s;

	assign mofs = '{OFS_ENABLE, OFS_PTR, OFS_NTR};

	always #20 sys_clk = ~sys_clk;

	ctrl_model ctrl_model_inst (.clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	status_register_sets #(.W(MASK_W)) status_register_sets_inst (
		.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .LIMIT_COND(cond[0]), .POWER_COND(cond[1]), .DATA_COND(cond[2]),
		.PRESET(preset), .LIMIT_SUMMARY(summ[0]), .POWER_SUMMARY(summ[1]),
		.DATA_SUMMARY(summ[2]), .IRQ(irq)
	);

	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	function automatic logic [MASK_W-1:0] rnd15();
		seed = xorshift(seed);
		return seed[MASK_W-1:0];
	endfunction

	// Expected event bits from a condition change under the transition masks
	function automatic logic [MASK_W-1:0] edge_ev(input logic [MASK_W-1:0] o, n, p, q);
		return (~o & n & p) | (o & ~n & q);
	endfunction

	function automatic logic [ADDR_W-1:0] ra(input int set, input logic [4:0] ofs);
		return 8'(set * 32) + {3'h0, ofs};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] v;
		ctrl_model_inst.read_reg(a, v);
		chk(v, exp);
	endtask

	task automatic results();
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#2000000;
		err_count++;
		results();
	end

	initial
	begin
		sys_clk     = 1'b0;
		reset       = 1'b1;
		preset      = 1'b0;
		cond        = '{default: '0};
		seed        = 32'd51;
		err_count   = 0;
		comparisons = 0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++)
			rd_chk(ra(i / 3, mofs[i % 3]), 32'h0);
		for (int i = 0; i < 9; i++)
		begin
			m[i / 3][i % 3] = rnd15();
			ctrl_model_inst.write_reg(ra(i / 3, mofs[i % 3]), {17'h0, m[i / 3][i % 3]});
		end
		// Upper bound is accepted, one above it is refused whole
		m[0][0] = 15'h7fff;
		ctrl_model_inst.write_reg(ra(0, OFS_ENABLE), 32'h0000_7fff);
		ctrl_model_inst.write_reg(ra(1, OFS_PTR), 32'h0000_8000);
		@(posedge sys_clk);
		preset <= 1'b1;
		@(posedge sys_clk);
		preset <= 1'b0;
		for (int i = 0; i < 9; i++)
			rd_chk(ra(i / 3, mofs[i % 3]), {17'h0, m[i / 3][i % 3]});
		rd_chk(OFS_IRQ_STATUS, 32'h0);
		ctrl_model_inst.write_reg(OFS_IRQ_MASK, 32'h8);
		chk({31'h0, irq}, 32'h0);
		ctrl_model_inst.write_reg(ra(2, OFS_NTR), 32'h0001_0000);
		rd_chk(OFS_IRQ_STATUS, 32'h8);
		chk({31'h0, irq}, 32'h1);
		rd_chk(ra(2, OFS_NTR), {17'h0, m[2][2]});
		ctrl_model_inst.write_reg(OFS_IRQ_MASK, 32'h0);
		// The mask lands on the write's own edge, so the level is looked at one edge later
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		ctrl_model_inst.write_reg(OFS_IRQ_STATUS, 32'h8);
		rd_chk(OFS_IRQ_STATUS, 32'h0);
		for (int it = 0; it < 15; it++)
		begin
			s  = it % 3;
			pt = rnd15();
			nt = rnd15();
			en = rnd15();
			od = rnd15();
			nw = rnd15();
			// First pass per set: every bit rises under a full mask
			if (it < 3)
			begin
				pt = 15'h7fff;
				od = 15'h0;
				nw = 15'h7fff;
			end
			// A falling bit under a set negative mask, which random values may miss
			if (it == 4)
			begin
				nt[1] = 1'b1;
				od[1] = 1'b1;
				nw[1] = 1'b0;
			end
			ctrl_model_inst.write_reg(ra(s, OFS_PTR), {17'h0, pt});
			ctrl_model_inst.write_reg(ra(s, OFS_NTR), {17'h0, nt});
			ctrl_model_inst.write_reg(ra(s, OFS_ENABLE), {17'h0, en});
			cond[s] <= od;
			repeat (5) @(posedge sys_clk);
			ctrl_model_inst.read_reg(ra(s, OFS_EVENT), d);
			ctrl_model_inst.write_reg(OFS_IRQ_STATUS, 32'hf);
			cond[s] <= nw;
			repeat (5) @(posedge sys_clk);
			ex = edge_ev(od, nw, pt, nt);
			chk({31'h0, summ[s]}, {31'h0, |(ex & en)});
			rd_chk(OFS_IRQ_STATUS, {31'h0, |(ex & en)} << s);
			ctrl_model_inst.read_pair(ra(s, OFS_COND), d, d2);
			chk(d, {17'h0, nw});
			chk(d2, {17'h0, nw});
			rd_chk(ra(s, OFS_EVENT), {17'h0, ex});
			rd_chk(ra(s, OFS_EVENT), 32'h0);
		end
		rd_chk(8'h7c, 32'h0);
		results();
	end
endmodule // tb_top
`default_nettype wire
